// >>> core/pmtr_top.sv
// file: table read engine with block protection over program flash
// Notes on behaviour
// - table reads and writes reach all program memory, gated only by protection
// - device id and configuration readable; configuration writable by table writes
// - external-access protect bits block external reads and writes, and table writes made while external mode is on
// - zero write-protect bit rejects table writes to its block while external mode is off
// - zero read-protect bit still allows reads from code in the same block
// - zero read-protect bit returns zeros to reads from other blocks
// - protection bits only go one to zero; writes toward one ignored
// - protection bits set only by reset or by erase started from external programmer
// - post variants read old pointer; pre-increment updates first
// - pointer is a 21-bit byte address over 2 Mbyte
// - pointer bit zero picks low or high byte of word
// - read takes two cycles, latch written in second, flags untouched
`timescale 1ns/10ps
`default_nettype none
module pmtr_top (
	input wire logic mclk,
	input wire logic rst,
	input wire pmtr_pkg::pmtr_instr_type instr,
	output logic busy,
	input wire logic ptr_load,
	input wire logic [20:0] ptr_load_val,
	input wire logic latch_load,
	input wire logic [7:0] latch_load_val,
	output logic [20:0] table_byte_pointer,
	output logic [7:0] table_data_latch,
	output logic read_done,
	output logic write_done,
	output logic write_rejected,
	input wire logic ext_mode,
	input wire logic ext_erase,
	input wire logic ext_rd,
	input wire logic ext_wr,
	input wire logic [20:0] ext_addr,
	input wire logic [7:0] ext_wdata,
	output logic [7:0] ext_rdata,
	output logic ext_rvalid,
	output pmtr_pkg::pmtr_prot_type prot_status
);
	typedef enum logic [2:0] {
		PMTR_IDLE = 3'h1,
		PMTR_READ = 3'h2,
		PMTR_EXTR = 3'h4
	} pmtr_state_type;
	pmtr_state_type state_q, state_d;
	logic [20:0] ptr_q;
	logic [7:0] latch_q;
	logic [7:0] cfg_q [0:7];
	logic [20:0] rd_addr_q;
	logic rd_block_ok_q;
	logic ext_mode_s1_q, ext_mode_q, ext_erase_s1_q, ext_erase_q, erase_prev_q;
	logic [15:0] mem_rdata;
	logic prot_wr, erase_pulse;
	logic [11:0] prot_wr_val;
	pmtr_pkg::pmtr_prot_type prot;
	logic is_rd, is_wt, mem_we;
	logic [1:0] variant;
	logic [20:0] ptr_inc, ptr_dec, rd_addr_d, wt_addr;
	logic [7:0] byte_sel, rd_byte;
	logic [1:0] wt_blk, rd_blk, pc_blk;
	logic wt_in_flash, wt_allowed, rd_allowed;

	// mode and erase pins from the programmer are synchronised before use
	always_ff @(posedge mclk) begin
		if (rst) begin
			ext_mode_s1_q <= 1'b0;
			ext_mode_q <= 1'b0;
			ext_erase_s1_q <= 1'b0;
			ext_erase_q <= 1'b0;
			erase_prev_q <= 1'b0;
		end else begin
			ext_mode_s1_q <= ext_mode;
			ext_mode_q <= ext_mode_s1_q;
			ext_erase_s1_q <= ext_erase;
			ext_erase_q <= ext_erase_s1_q;
			erase_prev_q <= ext_erase_q;
		end
	end
	// core code cannot reach the erase path at all
	assign erase_pulse = ext_mode_q && ext_erase_q && !erase_prev_q;

	assign is_rd = instr.valid && state_q == PMTR_IDLE
		&& instr.opcode[15:2] == pmtr_pkg::TABLE_READ_INSTRUCTION_OP;
	assign is_wt = instr.valid && state_q == PMTR_IDLE
		&& instr.opcode[15:2] == pmtr_pkg::TABLE_WRITE_INSTRUCTION_OP;
	assign variant = instr.opcode[1:0];
	assign ptr_inc = ptr_q + 21'h000001;
	assign ptr_dec = ptr_q - 21'h000001;
	assign rd_addr_d = (variant == pmtr_pkg::VAR_PREINC) ? ptr_inc : ptr_q;
	assign pc_blk = instr.pc[14:13];
	assign rd_blk = rd_addr_d[14:13];
	// cross-block reads blocked when the target block's read-protect bit is zero, same-block reads allowed
	assign rd_allowed = (rd_addr_d[20:15] != 6'h00) || prot.ebtr[rd_blk]
		|| (instr.pc[20:15] == 6'h00 && pc_blk == rd_blk);

	// table writes reuse the pointer as target and the latch as data, but take ext_addr and ext_wdata while external mode is on
	assign wt_addr = ext_mode_q ? ext_addr : ptr_q;
	assign wt_blk = wt_addr[14:13];
	assign wt_in_flash = wt_addr[20:15] == 6'h00;
	// external writes follow the external protect bits, not write-protect
	assign wt_allowed = ext_mode_q ? prot.cp[wt_blk] : prot.wrt[wt_blk];
	assign mem_we = (is_wt || (ext_mode_q && ext_wr)) && wt_in_flash && wt_allowed;

	pmtr_mem u_mem (
		.mclk(mclk),
		.raddr(ext_mode_q ? ext_addr[15:1] : rd_addr_d[15:1]),
		.rdata(mem_rdata),
		.we(mem_we),
		.waddr(wt_addr[15:1]),
		.wdata({ext_mode_q ? ext_wdata : latch_q, ext_mode_q ? ext_wdata : latch_q}),
		.wbe({wt_addr[0], !wt_addr[0]})
	);

	// the protection bytes sit at configuration offsets 5 and 6
	assign prot_wr = is_wt && !ext_mode_q && wt_addr[20:3] == pmtr_pkg::CFG_BASE[20:3]
		&& (wt_addr[2:0] == 3'h5 || wt_addr[2:0] == 3'h6);
	// byte 5 carries write-protect over read-protect, byte 6 the external bits
	assign prot_wr_val = (wt_addr[2:0] == 3'h5)
		? {latch_q[7:4], latch_q[3:0], prot.cp}
		: {prot.wrt, prot.ebtr, latch_q[3:0]};

	pmtr_prot u_prot (
		.mclk(mclk),
		.rst(rst),
		.wr(prot_wr),
		.wr_val(prot_wr_val),
		.erase(erase_pulse),
		.prot(prot)
	);

	// general configuration bytes are plain read-write storage
	always_ff @(posedge mclk) begin
		if (rst) begin
			for (int i = 0; i < 8; i++) begin
				cfg_q[i] <= 8'hFF;
			end
		end else if (is_wt && wt_addr[20:3] == pmtr_pkg::CFG_BASE[20:3]) begin
			cfg_q[wt_addr[2:0]] <= latch_q;
		end
	end

	always_comb begin
		state_d = state_q;
		case (state_q)
			PMTR_IDLE: begin
				if (is_rd) begin
					state_d = PMTR_READ;
				end else if (ext_mode_q && ext_rd) begin
					state_d = PMTR_EXTR;
				end
			end
			PMTR_READ: state_d = PMTR_IDLE;
			PMTR_EXTR: state_d = PMTR_IDLE;
			default: state_d = PMTR_IDLE;
		endcase
	end
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_q <= PMTR_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			rd_addr_q <= pmtr_pkg::PTR_RST;
			rd_block_ok_q <= 1'b0;
		end else if (is_rd) begin
			rd_addr_q <= rd_addr_d;
			rd_block_ok_q <= rd_allowed;
		end else if (state_q == PMTR_IDLE && ext_mode_q && ext_rd) begin
			rd_addr_q <= ext_addr;
			rd_block_ok_q <= ext_addr[20:15] != 6'h00 || prot.cp[ext_addr[14:13]];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			ptr_q <= pmtr_pkg::PTR_RST;
		end else if (is_rd) begin
			case (variant)
				pmtr_pkg::VAR_POSTINC: ptr_q <= ptr_inc;
				pmtr_pkg::VAR_POSTDEC: ptr_q <= ptr_dec;
				pmtr_pkg::VAR_PREINC: ptr_q <= ptr_inc;
				default: ptr_q <= ptr_q;
			endcase
		end else if (ptr_load) begin
			ptr_q <= ptr_load_val;
		end
	end

	assign byte_sel = rd_addr_q[0] ? mem_rdata[15:8] : mem_rdata[7:0];
	always_comb begin
		rd_byte = 8'h00;
		if (!rd_block_ok_q) begin
			rd_byte = 8'h00;
		end else if (rd_addr_q[20:1] == pmtr_pkg::DEVID_ADDR[20:1]) begin
			rd_byte = rd_addr_q[0] ? pmtr_pkg::DEVID_VAL[15:8]
				: pmtr_pkg::DEVID_VAL[7:0];
		end else if (rd_addr_q[20:3] == pmtr_pkg::CFG_BASE[20:3]) begin
			case (rd_addr_q[2:0])
				3'h5: rd_byte = {prot.wrt, prot.ebtr};
				3'h6: rd_byte = {4'hF, prot.cp};
				default: rd_byte = cfg_q[rd_addr_q[2:0]];
			endcase
		end else if (rd_addr_q[20:15] == 6'h00) begin
			rd_byte = byte_sel;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			latch_q <= pmtr_pkg::LATCH_RST;
		end else if (state_q == PMTR_READ) begin
			latch_q <= rd_byte;
		end else if (latch_load) begin
			latch_q <= latch_load_val;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			ext_rdata <= 8'h00;
			ext_rvalid <= 1'b0;
			write_done <= 1'b0;
			write_rejected <= 1'b0;
		end else begin
			ext_rvalid <= state_q == PMTR_EXTR;
			if (state_q == PMTR_EXTR) begin
				ext_rdata <= rd_byte;
			end
			write_done <= is_wt;
			write_rejected <= is_wt && wt_in_flash && !wt_allowed;
		end
	end

	assign busy = state_q != PMTR_IDLE;
	assign read_done = state_q == PMTR_READ;
	assign table_byte_pointer = ptr_q;
	assign table_data_latch = latch_q;
	assign prot_status = prot;

	sequence s_rd_issue;
		is_rd;
	endsequence
	sequence s_rd_finish;
		##1 read_done ##1 !busy;
	endsequence
	a_read_two_cycles: assert property (@(posedge mclk) disable iff (rst)
		s_rd_issue |-> s_rd_finish) else $error("table read not two cycles");
	a_postinc_ptr: assert property (@(posedge mclk) disable iff (rst)
		is_rd && variant == 2'h1 |=> ptr_q == $past(ptr_q) + 21'h000001)
		else $error("post increment wrong");
	a_postdec_ptr: assert property (@(posedge mclk) disable iff (rst)
		is_rd && variant == 2'h2 |=> ptr_q == $past(ptr_q) - 21'h000001)
		else $error("post decrement wrong");
	a_preinc_addr: assert property (@(posedge mclk) disable iff (rst)
		is_rd && variant == 2'h3 |=> rd_addr_q == ptr_q) else $error("pre increment address");
	a_nochange_ptr: assert property (@(posedge mclk) disable iff (rst)
		is_rd && variant == 2'h0 |=> $stable(ptr_q)) else $error("pointer moved");
	a_wrprot_block: assert property (@(posedge mclk) disable iff (rst)
		mem_we && !ext_mode_q |-> prot.wrt[wt_addr[14:13]]) else $error("protected write");
	a_xblock_zero: assert property (@(posedge mclk) disable iff (rst)
		read_done && !rd_block_ok_q |=> table_data_latch == 8'h00) else $error("leak");
	a_prot_monotone: assert property (@(posedge mclk) disable iff (rst)
		!erase_pulse |=> (prot & ~$past(prot)) == 12'h000) else $error("bit rose");
	// external read: accepted in idle, answered two edges later
	sequence s_ext_issue;
		state_q == PMTR_IDLE && !is_rd && ext_mode_q && ext_rd;
	endsequence
	sequence s_ext_finish;
		##1 busy ##1 ext_rvalid;
	endsequence
	a_ext_read_lag: assert property (@(posedge mclk) disable iff (rst)
		s_ext_issue |-> s_ext_finish) else $error("external read timing");
	a_ext_cp_zero: assert property (@(posedge mclk) disable iff (rst)
		state_q == PMTR_EXTR && !rd_block_ok_q |=> ext_rdata == 8'h00)
		else $error("protected external read leaked");
	a_ext_cp_write: assert property (@(posedge mclk) disable iff (rst)
		mem_we && ext_mode_q |-> prot.cp[wt_blk]) else $error("protected external write");
	a_erase_restore: assert property (@(posedge mclk) disable iff (rst)
		erase_pulse |=> prot == 12'hFFF) else $error("erase left bits clear");
	a_erase_mode: assert property (@(posedge mclk) disable iff (rst)
		erase_pulse |-> ext_mode_q) else $error("erase without programmer");
	a_prot_clear: assert property (@(posedge mclk) disable iff (rst)
		prot_wr && !erase_pulse |=> prot == ($past(prot) & $past(prot_wr_val)))
		else $error("protection write wrong");
	a_write_reject: assert property (@(posedge mclk) disable iff (rst)
		is_wt && wt_in_flash && !wt_allowed |=> write_rejected)
		else $error("reject flag missing");
	a_ptr_wrap: assert property (@(posedge mclk) disable iff (rst)
		is_rd && variant == pmtr_pkg::VAR_POSTINC && ptr_q == 21'h1FFFFF
		|=> ptr_q == 21'h000000) else $error("pointer did not wrap");
	a_ptr_load: assert property (@(posedge mclk) disable iff (rst)
		ptr_load && !is_rd |=> ptr_q == $past(ptr_load_val)) else $error("pointer load lost");
	a_low_byte: assert property (@(posedge mclk) disable iff (rst)
		read_done && rd_block_ok_q && rd_addr_q[20:15] == 6'h00 && !rd_addr_q[0]
		|=> table_data_latch == $past(mem_rdata[7:0])) else $error("wrong low byte");
	a_high_byte: assert property (@(posedge mclk) disable iff (rst)
		read_done && rd_block_ok_q && rd_addr_q[20:15] == 6'h00 && rd_addr_q[0]
		|=> table_data_latch == $past(mem_rdata[15:8])) else $error("wrong high byte");
	// the latch moves only at a read completion or a core load
	a_latch_hold: assert property (@(posedge mclk) disable iff (rst)
		!read_done && !latch_load |=> $stable(table_data_latch)) else $error("latch moved");
endmodule
`default_nettype wire

// >>> core/pmtr_pkg.sv
// package: constants and carriers for the program memory table read block
package pmtr_pkg;
	localparam int PTR_W = 21;
	localparam int BLK_W = 2;
	localparam int NBLK = 4;
	localparam int BLK_SHIFT = 13;
	localparam logic [20:0] PTR_RST = 21'h000000;
	localparam logic [7:0] LATCH_RST = 8'h00;
	localparam logic [3:0] PROT_RST = 4'hF;
	localparam logic [13:0] TABLE_READ_INSTRUCTION_OP = 14'h0002;
	localparam logic [13:0] TABLE_WRITE_INSTRUCTION_OP = 14'h0003;
	localparam logic [1:0] VAR_NONE = 2'h0;
	localparam logic [1:0] VAR_POSTINC = 2'h1;
	localparam logic [1:0] VAR_POSTDEC = 2'h2;
	localparam logic [1:0] VAR_PREINC = 2'h3;
	localparam int CFG_W = 8;
	localparam logic [20:0] CFG_BASE = 21'h100000;
	localparam logic [20:0] DEVID_ADDR = 21'h1FFFFE;
	localparam logic [15:0] DEVID_VAL = 16'h5A5A;
	localparam int MEM_AW = 15;
	typedef struct packed {
		logic valid;
		logic [15:0] opcode;
		logic [20:0] pc;
	} pmtr_instr_type;
	typedef struct packed {
		logic [3:0] wrt;
		logic [3:0] ebtr;
		logic [3:0] cp;
	} pmtr_prot_type;
endpackage

// >>> core/pmtr_mem.sv
// file: program word store with registered read data
`timescale 1ns/10ps
`default_nettype none
module pmtr_mem (
	input wire logic mclk,
	input wire logic [14:0] raddr,
	output logic [15:0] rdata,
	input wire logic we,
	input wire logic [14:0] waddr,
	input wire logic [15:0] wdata,
	input wire logic [1:0] wbe
);
	logic [15:0] mem [0:32767];
	always_ff @(posedge mclk) begin
		rdata <= mem[raddr];
	end
	always_ff @(posedge mclk) begin
		if (we && wbe[0]) begin
			mem[waddr][7:0] <= wdata[7:0];
		end
		if (we && wbe[1]) begin
			mem[waddr][15:8] <= wdata[15:8];
		end
	end
endmodule
`default_nettype wire

// >>> core/pmtr_prot.sv
// file: protection bit store, clear only by writes, set only by reset or external erase
`timescale 1ns/10ps
`default_nettype none
module pmtr_prot (
	input wire logic mclk,
	input wire logic rst,
	input wire logic wr,
	input wire logic [11:0] wr_val,
	input wire logic erase,
	output pmtr_pkg::pmtr_prot_type prot
);
	logic [11:0] bits_q;
	always_ff @(posedge mclk) begin
		if (rst) begin
			bits_q <= {3{pmtr_pkg::PROT_RST}};
		end else if (erase) begin
			bits_q <= {3{pmtr_pkg::PROT_RST}};
		end else if (wr) begin
			// only 1 to 0 transitions take effect
			bits_q <= bits_q & wr_val;
		end
	end
	assign prot = bits_q;
endmodule
`default_nettype wire

// >>> verif/pmtr_prog.sv
// programmer model: raises the mode pin and strobes a chip erase
`timescale 1ns/10ps
`default_nettype none
module pmtr_prog (
	input wire logic mclk,
	input wire logic erase_go,
	output logic ext_mode,
	output logic ext_erase
);
	int cnt = 0;
	// erase waits until the mode pin has had time to pass the synchronizer
	always @(posedge mclk) begin
		if (cnt != 0 || erase_go) begin
			cnt <= (cnt == 24) ? 0 : cnt + 1;
		end
	end
	assign ext_mode = cnt != 0;
	assign ext_erase = cnt >= 8 && cnt < 16;
endmodule
`default_nettype wire

// >>> verif/pmtr_top_test.sv
// testbench: table read engine against a byte-level reference model
`timescale 1ns/10ps
`default_nettype none
module pmtr_top_test;
	logic mclk, rst, busy, ptr_load, latch_load, read_done, write_done, write_rejected;
	logic ext_mode, ext_erase, erase_go, ext_rd, ext_wr, ext_rvalid;
	logic [20:0] ptr_load_val, table_byte_pointer, ext_addr;
	logic [7:0] latch_load_val, table_data_latch, ext_wdata, ext_rdata;
	pmtr_pkg::pmtr_instr_type instr;
	pmtr_pkg::pmtr_prot_type prot_status;
	int mem [int];
	int wrt, ebtr, cp, bad_count, cmp_count, cycles, seed, i, a;
	pmtr_top DUT (.mclk(mclk), .rst(rst), .instr(instr), .busy(busy), .ptr_load(ptr_load),
		.ptr_load_val(ptr_load_val), .latch_load(latch_load), .latch_load_val(latch_load_val),
		.table_byte_pointer(table_byte_pointer), .table_data_latch(table_data_latch),
		.read_done(read_done), .write_done(write_done), .write_rejected(write_rejected),
		.ext_mode(ext_mode), .ext_erase(ext_erase), .ext_rd(ext_rd), .ext_wr(ext_wr),
		.ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata),
		.ext_rvalid(ext_rvalid),
		.prot_status(prot_status));
	pmtr_prog PRG (.mclk(mclk), .erase_go(erase_go), .ext_mode(ext_mode), .ext_erase(ext_erase));
	task automatic check(input string what, input logic [20:0] seen, input logic [20:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	function automatic int exp_byte(input int ad, input int pc);
		if (ad < 21'h008000)
			return (!ebtr[ad[14:13]] && pc[14:13] != ad[14:13]) ? 0 : mem[ad];
		if (ad == 21'h100005) return (wrt << 4) | ebtr;
		if (ad == 21'h100006) return 8'hF0 | cp;
		if (ad >= 21'h1FFFFE) return ad[0] ? pmtr_pkg::DEVID_VAL[15:8] : pmtr_pkg::DEVID_VAL[7:0];
		return 0;
	endfunction
	task automatic twr(input int ad, input int d);
		logic rej;
		rej = ad < 21'h008000 && !wrt[ad[14:13]];
		@(posedge mclk);
		ptr_load <= 1'b1;
		ptr_load_val <= ad[20:0];
		latch_load <= 1'b1;
		latch_load_val <= d[7:0];
		@(posedge mclk);
		ptr_load <= 1'b0;
		latch_load <= 1'b0;
		instr <= {1'b1, pmtr_pkg::TABLE_WRITE_INSTRUCTION_OP, pmtr_pkg::VAR_NONE, 21'h000000};
		@(posedge mclk);
		instr.valid <= 1'b0;
		repeat (3) begin
			#1;
			if (write_done || write_rejected) break;
			@(posedge mclk);
		end
		check("write_rejected", write_rejected, rej);
		check("write_done", write_done, 1'b1);
		if (!rej && ad < 21'h008000) mem[ad] = d;
		if (ad == 21'h100005) wrt &= d >> 4;
		if (ad == 21'h100005) ebtr &= d & 15;
		if (ad == 21'h100006) cp &= d & 15;
	endtask
	task automatic trd(input int ad, input int v, input int pc);
		int ra, np;
		@(posedge mclk);
		ptr_load <= 1'b1;
		ptr_load_val <= ad[20:0];
		@(posedge mclk);
		ptr_load <= 1'b0;
		instr <= {1'b1, pmtr_pkg::TABLE_READ_INSTRUCTION_OP, v[1:0], pc[20:0]};
		@(posedge mclk);
		instr.valid <= 1'b0;
		ra = (v == 3) ? (ad + 1) & 21'h1FFFFF : ad;
		np = (v == 0) ? ad : (v == 2) ? (ad - 1) & 21'h1FFFFF : (ad + 1) & 21'h1FFFFF;
		#1;
		check("read_done", read_done, 1'b1);
		check("busy", busy, 1'b1);
		check("pointer", table_byte_pointer, np);
		@(posedge mclk);
		#1;
		check("latch", table_data_latch, exp_byte(ra, pc));
	endtask
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			final_report();
		end
	end
	initial begin
		seed = 32'h5AA3;
		{rst, ptr_load, latch_load, erase_go} = 4'h8;
		{ext_rd, ext_wr} = 2'h0;
		ext_addr = 21'h000000;
		ext_wdata = 8'h00;
		instr = '0;
		ptr_load_val = 21'h000000;
		latch_load_val = 8'h00;
		wrt = 15;
		ebtr = 15;
		cp = 15;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		#1;
		check("prot", prot_status, 21'h000FFF);
		check("reset pointer", table_byte_pointer, 21'h000000);
		twr(0, 8'hC3);
		twr(21'h002010, 8'h11);
		twr(21'h004020, 8'h22);
		for (i = 0; i < 12; i++) begin
			a = $random(seed) & 21'h007FFF;
			twr(a, $random(seed) & 8'hFF);
			// the pre-increment read lands on the next byte, so it must hold data
			twr(a + 1, $random(seed) & 8'hFF);
			trd(a, i % 4, a);
		end
		trd(21'h1FFFFF, 1, 0);
		trd(0, 2, 0);
		trd(21'h1FFFFE, 3, 0);
		twr(21'h100005, 8'hDB);
		twr(21'h100006, 8'hFE);
		check("prot", prot_status, {wrt[3:0], ebtr[3:0], cp[3:0]});
		twr(21'h002010, 8'h77);
		trd(21'h002010, 0, 0);
		trd(21'h004020, 0, 0);
		trd(21'h004020, 1, 21'h004000);
		trd(0, 0, 0);
		twr(21'h100005, 8'hFF);
		check("prot", prot_status, {wrt[3:0], ebtr[3:0], cp[3:0]});
		@(posedge mclk);
		erase_go <= 1'b1;
		@(posedge mclk);
		erase_go <= 1'b0;
		// external accesses fit between the mode sync and the erase strobe
		repeat (3) @(posedge mclk);
		ext_rd <= 1'b1;
		ext_addr <= 21'h000000;
		@(posedge mclk);
		ext_rd <= 1'b0;
		ext_wr <= 1'b1;
		ext_addr <= 21'h002011;
		ext_wdata <= 8'h5C;
		@(posedge mclk);
		ext_wr <= 1'b0;
		ext_rd <= 1'b1;
		mem[21'h002011] = 8'h5C;
		#1;
		check("ext_rvalid", ext_rvalid, 1'b1);
		check("ext_rdata", ext_rdata, (cp & 1) ? mem[0] : 0);
		@(posedge mclk);
		ext_rd <= 1'b0;
		#1;
		check("ext_rvalid", ext_rvalid, 1'b0);
		@(posedge mclk);
		#1;
		check("ext_rvalid", ext_rvalid, 1'b1);
		check("ext_rdata", ext_rdata, mem[21'h002011]);
		repeat (24) @(posedge mclk);
		{wrt, ebtr, cp} = {32'd15, 32'd15, 32'd15};
		#1;
		check("prot", prot_status, 21'h000FFF);
		twr(21'h002010, 8'h66);
		trd(21'h002010, 0, 0);
		trd(21'h002011, 0, 0);
		final_report();
	end
endmodule
`default_nettype wire
